// >>> shared/hsp_pkg.sv
// Constants, field layout and carrier types of the handshaked serial port.
// Assumes an APB slave on pclk; the serial link is sampled from pclk.
// Functional notes
// - Output reset bit resets output, self-clears
// - Input reset bit resets input, self-clears
// - Store while not enabled sets sticky error
// - Load while not enabled sets sticky error
// - Store flag set on transfer, cleared by store
// - Load flag set on word, cleared by load
// - Continuous/single bits select input mode
// - Store clears flag; wait stalls further stores
// - Data moves to shifter after 3 clocks
// - Enable sampled falling; request drops, shifting starts
// - Empty register sets flag, releases wait, pulses
// - Data pin floats after last bit idle
// - Early enable continues output seamlessly
// - Input enable sampled, ack drops, bits captured
// - Ack rises in last bit cycle
// - Completed word moves in, flag set, pulse
// - Load clears flag; wait stalls further loads
// - Early input enable starts next word directly
// - 8 or 16 bit words, MSB or LSB first
// - Separate in and out registers, one address
package hsp_pkg;
    // Register byte offsets
    localparam logic [11:0] HSP_DATA_OFS   = 12'h000;
    localparam logic [11:0] HSP_STATUS_OFS = 12'h004;
    // Status field positions
    localparam int HSP_B_OUT_LSB   = 15;
    localparam int HSP_B_IN_LSB    = 14;
    localparam int HSP_B_OUT_LEN   = 13;
    localparam int HSP_B_IN_LEN    = 12;
    localparam int HSP_B_STORE_WT  = 11;
    localparam int HSP_B_LOAD_WT   = 10;
    localparam int HSP_B_IN_CONT   = 9;
    localparam int HSP_B_IN_SINGLE = 8;
    localparam int HSP_B_OUT_RST   = 5;
    localparam int HSP_B_IN_RST    = 4;
    localparam int HSP_B_STORE_ERR = 3;
    localparam int HSP_B_LOAD_ERR  = 2;
    localparam int HSP_B_STORE_OK  = 1;
    localparam int HSP_B_LOAD_OK   = 0;
    // Reset value of status and data
    localparam logic [15:0] HSP_STATUS_RST = 16'h0002;
    localparam logic [15:0] HSP_DATA_RST   = 16'h0000;
    // Serial clocks from store to shifter transfer
    localparam logic [1:0]  HSP_XFER_CLKS  = 2'h3;
    // Word lengths
    localparam logic [4:0]  HSP_LEN_LONG   = 5'h10;
    localparam logic [4:0]  HSP_LEN_SHORT  = 5'h08;
    // Mode bits kept in the status register
    typedef struct packed {
        logic out_lsb;
        logic in_lsb;
        logic out_word_len;
        logic in_word_len;
        logic store_wait_en;
        logic load_wait_en;
        logic in_continuous_bit;
        logic in_single_start;
    } hsp_mode_t;
    // Pins toward the external serial device
    typedef struct packed {
        logic out_request_pin;
        logic in_ack_pin;
        logic ser_data_out_pin;
        logic ser_data_out_oe_n;
    } hsp_pins_out_t;
endpackage : hsp_pkg

// >>> rtl/hsp_core.sv
// Handshaked serial port: APB registers plus serial output and input engines.
// Assumes ser_clk_pin and the handshake pins are asynchronous to pclk and much slower.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
module hsp_core
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Serial pins in
    input  wire logic                 ser_clk_pin,
    input  wire logic                 out_enable_pin,
    input  wire logic                 in_enable_pin,
    input  wire logic                 ser_data_in_pin,
    // Serial pins out
    output hsp_pkg::hsp_pins_out_t    pins_out,
    // Completion pulses
    output logic                      out_done_pulse,
    output logic                      in_done_pulse
);
    // Two-stage synchronisers: clock, out enable, in enable, data
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic       clk_prev_reg;              // Previous synced serial clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg    <= 4'h0;
            sync2_reg    <= 4'h0;
            clk_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= {ser_clk_pin, out_enable_pin, in_enable_pin, ser_data_in_pin};
            sync2_reg    <= sync1_reg;
            clk_prev_reg <= sync2_reg[3];
        end
    end
    // Serial clock edges seen from pclk
    wire rise_w = sync2_reg[3] & ~clk_prev_reg;
    wire fall_w = ~sync2_reg[3] & clk_prev_reg;
    wire oen_w  = sync2_reg[2];
    wire ien_w  = sync2_reg[1];
    wire din_w  = sync2_reg[0];

    // APB decode; the access phase is the moment of effect
    wire acc_w      = psel & penable;
    wire hit_data_w = (paddr == hsp_pkg::HSP_DATA_OFS);
    wire hit_stat_w = (paddr == hsp_pkg::HSP_STATUS_OFS);
    wire unmap_w    = ~hit_data_w & ~hit_stat_w;
    // Status fields
    hsp_pkg::hsp_mode_t mode_reg;
    logic out_rst_reg;                     // out_reset_req
    logic in_rst_reg;                      // in_reset_req
    logic store_err_flag;
    logic load_err_flag;
    logic store_ok_flag;
    logic load_ok_flag;
    // Wait stalls hold pready low until the flag allows the access
    wire store_stall_w = hit_data_w & pwrite & mode_reg.store_wait_en & ~store_ok_flag;
    wire load_stall_w  = hit_data_w & ~pwrite & mode_reg.load_wait_en & ~load_ok_flag;
    assign pready  = ~(store_stall_w | load_stall_w);
    assign pslverr = unmap_w;
    wire done_w       = acc_w & pready & ~unmap_w;
    wire store_w      = done_w & hit_data_w & pwrite;
    wire load_w       = done_w & hit_data_w & ~pwrite;
    wire stat_wr_w    = done_w & hit_stat_w & pwrite;

    // Data registers: separate out and in words at one address
    logic [15:0] data_out_reg;
    logic [15:0] data_in_reg;
    logic        out_full_reg;             // data_out holds an unsent word
    // Output engine state
    logic [15:0] out_shifter;
    logic [4:0]  out_cnt_reg;              // Bits left to send
    logic        out_loaded_reg;           // Shifter holds a word awaiting enable
    logic        out_active_reg;           // Shifting in progress
    logic        oen_seen_reg;             // Enable sampled on falling edge
    logic [1:0]  xfer_cnt_reg;             // Rising edges since store
    logic        req_reg;
    logic        dout_reg;
    logic        oe_n_reg;
    // Input engine state
    logic [15:0] in_shifter;
    logic [4:0]  in_cnt_reg;               // Bits captured
    logic        in_active_reg;
    logic        ien_seen_reg;
    logic        ack_reg;
    logic        single_armed_reg;         // One single-mode word allowed
    logic        in_word_rdy;              // Completed word waits in shifter

    // Word lengths and shift helpers
    wire [4:0] out_len_w = mode_reg.out_word_len ? hsp_pkg::HSP_LEN_SHORT : hsp_pkg::HSP_LEN_LONG;
    wire [4:0] in_len_w  = mode_reg.in_word_len ? hsp_pkg::HSP_LEN_SHORT : hsp_pkg::HSP_LEN_LONG;
    wire out_bit_w = mode_reg.out_lsb ? out_shifter[0]
                   : (mode_reg.out_word_len ? out_shifter[7] : out_shifter[15]);
    function automatic logic [15:0] hsp_shift_in(input logic [15:0] s, input logic b,
                                                 input logic lsb, input logic short_w);
        logic [15:0] r;
        // Short words keep the upper byte clear, as in the LSB-first case
        r = short_w ? {8'h00, s[6:0], b} : {s[14:0], b};
        if (lsb)
            r = short_w ? {8'h00, b, s[7:1]} : {b, s[15:1]};
        return r;
    endfunction : hsp_shift_in
    // input enabled by continuous mode or an armed single start
    wire in_allow_w = mode_reg.in_continuous_bit | single_armed_reg;
    // start output on rising edge after sampled enable
    wire out_start_w = rise_w & out_loaded_reg & oen_seen_reg & ~out_active_reg;
    // last bit with next word ready and enable sampled continues
    wire out_last_w  = rise_w & out_active_reg & (out_cnt_reg == 5'h01);
    wire out_chain_w = out_last_w & out_full_reg & oen_seen_reg;

    // Status register and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg       <= '0;
            out_rst_reg    <= 1'b0;
            in_rst_reg     <= 1'b0;
            store_err_flag <= 1'b0;
            load_err_flag  <= 1'b0;
        end
        else
        begin
            mode_reg.in_single_start <= 1'b0;
            // reset requests self-clear once acted on
            out_rst_reg <= 1'b0;
            in_rst_reg  <= 1'b0;
            if (stat_wr_w)
            begin
                mode_reg <= pwdata[15:8];
                out_rst_reg <= pwdata[hsp_pkg::HSP_B_OUT_RST];
                in_rst_reg  <= pwdata[hsp_pkg::HSP_B_IN_RST];
                // Error flags clear by writing 0 or by the matching reset request
                if (!pwdata[hsp_pkg::HSP_B_STORE_ERR])
                    store_err_flag <= 1'b0;
                if (!pwdata[hsp_pkg::HSP_B_LOAD_ERR])
                    load_err_flag <= 1'b0;
            end
            // store error, out reset request wins over set
            if (store_w && !store_ok_flag)
                store_err_flag <= 1'b1;
            // load error, in reset request wins over set
            if (load_w && !load_ok_flag)
                load_err_flag <= 1'b1;
            if (out_rst_reg)
                store_err_flag <= 1'b0;
            if (in_rst_reg)
                load_err_flag <= 1'b0;
        end
    end

    // Output data register and store flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_out_reg  <= hsp_pkg::HSP_DATA_RST;
            out_full_reg  <= 1'b0;
            store_ok_flag <= 1'b1;
            xfer_cnt_reg  <= 2'h0;
        end
        else if (out_rst_reg)
        begin
            out_full_reg  <= 1'b0;
            store_ok_flag <= 1'b1;
            xfer_cnt_reg  <= 2'h0;
        end
        else if (store_w)
        begin
            data_out_reg  <= pwdata[15:0];
            out_full_reg  <= 1'b1;
            store_ok_flag <= 1'b0;
            xfer_cnt_reg  <= 2'h0;
        end
        else if (out_chain_w || (rise_w && out_full_reg && !out_loaded_reg && !out_active_reg
                                 && xfer_cnt_reg >= hsp_pkg::HSP_XFER_CLKS - 2'h1))
        begin
            // transfer to shifter sets store flag
            out_full_reg  <= 1'b0;
            store_ok_flag <= 1'b1;
        end
        else if (rise_w && out_full_reg && xfer_cnt_reg != hsp_pkg::HSP_XFER_CLKS)
            xfer_cnt_reg <= xfer_cnt_reg + 2'h1;
    end
    // transfer on the third rising edge after store
    // Count saturates while the shifter is busy, hence the >= compare
    wire out_xfer_w = out_full_reg & ~out_rst_reg & ~store_w &
                      ((rise_w & ~out_loaded_reg & ~out_active_reg &
                        (xfer_cnt_reg >= hsp_pkg::HSP_XFER_CLKS - 2'h1)) | out_chain_w);

    // Output shifter and pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_shifter    <= 16'h0000;
            out_cnt_reg    <= 5'h00;
            out_loaded_reg <= 1'b0;
            out_active_reg <= 1'b0;
            oen_seen_reg   <= 1'b0;
            req_reg        <= 1'b0;
            dout_reg       <= 1'b0;
            oe_n_reg       <= 1'b1;
        end
        else if (out_rst_reg)
        begin
            out_loaded_reg <= 1'b0;
            out_active_reg <= 1'b0;
            oen_seen_reg   <= 1'b0;
            req_reg        <= 1'b0;
            oe_n_reg       <= 1'b1;
        end
        else
        begin
            if (fall_w)
                oen_seen_reg <= oen_w;
            if (out_chain_w)
            begin
                // next word follows with no gap
                out_shifter <= data_out_reg;
                out_cnt_reg <= out_len_w;
                dout_reg    <= mode_reg.out_lsb ? data_out_reg[0]
                             : (mode_reg.out_word_len ? data_out_reg[7] : data_out_reg[15]);
                req_reg     <= 1'b0;
            end
            else if (out_xfer_w)
            begin
                // raise request once shifter is loaded
                out_shifter    <= data_out_reg;
                out_loaded_reg <= 1'b1;
                req_reg        <= 1'b1;
            end
            else if (out_start_w)
            begin
                // request drops and first bit is driven
                out_loaded_reg <= 1'b0;
                out_active_reg <= 1'b1;
                out_cnt_reg    <= out_len_w;
                req_reg        <= 1'b0;
                dout_reg       <= out_bit_w;
                oe_n_reg       <= 1'b0;
            end
            else if (out_last_w)
            begin
                out_active_reg <= 1'b0;
                oe_n_reg       <= 1'b1;
            end
            else if (rise_w && out_active_reg)
            begin
                out_shifter <= mode_reg.out_lsb ? {1'b0, out_shifter[15:1]} : {out_shifter[14:0], 1'b0};
                out_cnt_reg <= out_cnt_reg - 5'h01;
                dout_reg    <= mode_reg.out_lsb ? out_shifter[1]
                             : (mode_reg.out_word_len ? out_shifter[6] : out_shifter[14]);
            end
        end
    end

    // Input shifter, ack and word handover
    wire in_last_w = fall_w & in_active_reg & (in_cnt_reg == in_len_w - 5'h01);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_shifter       <= 16'h0000;
            in_cnt_reg       <= 5'h00;
            in_active_reg    <= 1'b0;
            ien_seen_reg     <= 1'b0;
            ack_reg          <= 1'b0;
            single_armed_reg <= 1'b0;
            in_word_rdy      <= 1'b0;
        end
        else if (in_rst_reg)
        begin
            in_active_reg    <= 1'b0;
            ien_seen_reg     <= 1'b0;
            ack_reg          <= 1'b0;
            single_armed_reg <= 1'b0;
            in_word_rdy      <= 1'b0;
        end
        else
        begin
            if (mode_reg.in_single_start)
                single_armed_reg <= 1'b1;
            // Ack shows readiness when input is allowed and idle
            if (rise_w && !in_active_reg && !ien_seen_reg)
                ack_reg <= in_allow_w;
            // enable sampled on falling edge while ack high
            if (fall_w && !in_active_reg)
                ien_seen_reg <= ien_w & ack_reg;
            // enable sampled on falling edges before the last bit
            if (fall_w && in_active_reg && !in_last_w)
                ien_seen_reg <= ien_w & in_allow_w;
            if (rise_w && ien_seen_reg && !in_active_reg)
            begin
                // ack drops, capture begins this cycle
                ack_reg          <= 1'b0;
                in_active_reg    <= 1'b1;
                in_cnt_reg       <= 5'h00;
                ien_seen_reg     <= 1'b0;
                single_armed_reg <= 1'b0;
            end
            // ack rises in the last bit cycle
            if (rise_w && in_active_reg && in_cnt_reg == in_len_w - 5'h01)
                ack_reg <= ~ien_seen_reg & in_allow_w;
            if (fall_w && in_active_reg)
            begin
                in_shifter <= hsp_shift_in(in_shifter, din_w, mode_reg.in_lsb, mode_reg.in_word_len);
                in_cnt_reg <= in_cnt_reg + 5'h01;
            end
            if (in_last_w)
            begin
                in_word_rdy   <= 1'b1;
                in_cnt_reg    <= 5'h00;
                in_active_reg <= ien_seen_reg;
                ien_seen_reg  <= 1'b0;
            end
            else if (in_word_rdy && !load_ok_flag)
                in_word_rdy <= 1'b0;
        end
    end

    // Input data register and load flag
    wire in_move_w = in_word_rdy & ~load_ok_flag & ~in_rst_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_in_reg  <= hsp_pkg::HSP_DATA_RST;
            load_ok_flag <= 1'b0;
        end
        else if (in_rst_reg)
            load_ok_flag <= 1'b0;
        else if (in_move_w)
        begin
            // word moves in and load flag sets
            data_in_reg  <= in_shifter;
            load_ok_flag <= 1'b1;
        end
        else if (load_w)
            load_ok_flag <= 1'b0;
    end

    // completion pulses, one pclk cycle each
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_done_pulse <= 1'b0;
            in_done_pulse  <= 1'b0;
        end
        else
        begin
            out_done_pulse <= out_xfer_w;
            in_done_pulse  <= in_move_w;
        end
    end

    // Read data, driven only in the access phase
    // load reads the input word
    wire [15:0] status_w = {mode_reg, 2'b00, out_rst_reg, in_rst_reg,
                            store_err_flag, load_err_flag, store_ok_flag, load_ok_flag};
    assign prdata = !acc_w ? 32'h0000_0000 : hit_stat_w ? {16'h0000, status_w}
                  : hit_data_w ? {16'h0000, data_in_reg} : 32'h0000_0000;
    assign pins_out = '{out_request_pin: req_reg, in_ack_pin: ack_reg,
                        ser_data_out_pin: dout_reg, ser_data_out_oe_n: oe_n_reg};

    // stalled store waits for store flag
    a_store_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
        store_w |-> (store_ok_flag || !mode_reg.store_wait_en)) else $error("store not stalled");
    a_store_err_set: assert property (@(posedge pclk) disable iff (!presetn)
        (store_w && !store_ok_flag) |=> store_err_flag) else $error("store error missed");
    a_load_err_set: assert property (@(posedge pclk) disable iff (!presetn)
        (load_w && !load_ok_flag && !in_move_w) |=> load_err_flag) else $error("load error missed");
    a_out_reset_done: assert property (@(posedge pclk) disable iff (!presetn)
        out_rst_reg |=> (store_ok_flag && !store_err_flag && !out_rst_reg)) else $error("out reset bad");
    a_in_reset_done: assert property (@(posedge pclk) disable iff (!presetn)
        in_rst_reg |=> (!load_ok_flag && !load_err_flag && !in_rst_reg)) else $error("in reset bad");
    a_store_clears_ok: assert property (@(posedge pclk) disable iff (!presetn)
        store_w |=> !store_ok_flag) else $error("store flag not cleared");
    // word arrival sets load flag and pulse
    sequence s_word_in;
        in_move_w ##1 load_ok_flag;
    endsequence
    a_word_in_flag: assert property (@(posedge pclk) disable iff (!presetn)
        in_move_w |-> s_word_in and (##1 in_done_pulse)) else $error("word move bad");
    a_out_float: assert property (@(posedge pclk) disable iff (!presetn)
        (out_last_w && !out_chain_w && !out_rst_reg) |=> oe_n_reg) else $error("pin not floated");
    a_done_single: assert property (@(posedge pclk) disable iff (!presetn)
        out_done_pulse |=> !out_done_pulse) else $error("pulse too long");
endmodule : hsp_core

// >>> verification/hsp_far_end.sv
// Model of the external serial device: free serial clock, enable handshakes.
// Assumes the port's pins_out struct; the bench calls send and recv.
`timescale 1ns/100ps
module hsp_far_end
(
    // Toward the port
    output logic                   ser_clk_pin,
    output logic                   out_enable_pin,
    output logic                   in_enable_pin,
    output logic                   ser_data_in_pin,
    // From the port
    input  hsp_pkg::hsp_pins_out_t pins_out
);
    // Clock runs free, so the three-edge lead-in is always given
    // continuous rising edges
    initial
    begin
        ser_clk_pin = 1'b0;
        out_enable_pin = 1'b0;
        in_enable_pin = 1'b0;
        ser_data_in_pin = 1'b0;
        forever #160 ser_clk_pin = ~ser_clk_pin;
    end

    // Take one word; a bit seen while not driven becomes unknown
    // enable raised after request
    // Chain asks for the next word in the final bit cycle; cont skips the request wait
    task automatic recv(input int n, input logic lsb, input logic chain, input logic cont,
                        output logic [15:0] w);
        int i;
        w = 16'h0000;
        if (!cont)
        begin
            do @(posedge ser_clk_pin); while (pins_out.out_request_pin !== 1'b1);
            out_enable_pin <= 1'b1;
            @(posedge ser_clk_pin);
            out_enable_pin <= 1'b0;
        end
        for (i = 0; i < n; i++)
        begin
            @(posedge ser_clk_pin);
            w[lsb ? i : n - 1 - i] = pins_out.ser_data_out_oe_n ? 1'bx : pins_out.ser_data_out_pin;
            // enable held over the final bit cycle
            if (chain)
                out_enable_pin <= (i == n - 2);
        end
    endtask : recv

    // Give one word once acknowledge is up; bits change on rising edges
    // enable only while acknowledged
    task automatic send(input logic [15:0] w, input int n, input logic lsb);
        int i;
        do @(posedge ser_clk_pin); while (pins_out.in_ack_pin !== 1'b1);
        in_enable_pin <= 1'b1;
        @(posedge ser_clk_pin);
        in_enable_pin <= 1'b0;
        for (i = 0; i < n; i++)
        begin
            ser_data_in_pin <= w[lsb ? i : n - 1 - i];
            @(posedge ser_clk_pin);
        end
        // Line no longer held: show the inverse
        ser_data_in_pin <= ~ser_data_in_pin;
    endtask : send
endmodule : hsp_far_end

// >>> verification/handshaked_serial_port_core_bench.sv
// Self-checking bench of the serial port over APB with a far-end model.
// Assumes hsp_pkg and hsp_core; all checks in one task.
`timescale 1ns/100ps
module handshaked_serial_port_core_bench;
    localparam logic [11:0] DAT = hsp_pkg::HSP_DATA_OFS;
    localparam logic [11:0] STA = hsp_pkg::HSP_STATUS_OFS;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sclk, oen, ien, sdi, in_done, out_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] w1, w2;
    int          n_errors, checks_done, cycles, n_in_done, n_out_done;
    hsp_pkg::hsp_pins_out_t pins;

    hsp_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ser_clk_pin(sclk), .out_enable_pin(oen), .in_enable_pin(ien), .ser_data_in_pin(sdi),
        .pins_out(pins), .out_done_pulse(out_done), .in_done_pulse(in_done));
    hsp_far_end far (.ser_clk_pin(sclk), .out_enable_pin(oen), .in_enable_pin(ien),
        .ser_data_in_pin(sdi), .pins_out(pins));

    // 25 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer; waits for pready, takes data at that edge
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        check("pslverr", {31'h0, pslverr}, {31'h0, a == 12'h0FC});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check(name, rdat, exp);
    endtask : rd_chk

    // Pulses are counted by the clock process; a missing one counts as a mismatch
    task automatic wait_in(input int target);
        int n;
        for (n = 0; n < 400 && n_in_done < target; n++) @(posedge pclk);
        check("in pulses", n_in_done, target);
    endtask : wait_in

    // Hang guard: counts as a mismatch
    always @(posedge pclk)
    begin
        cycles++;
        if (in_done === 1'b1)
            n_in_done++;
        if (out_done === 1'b1)
            n_out_done++;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("status rst", STA, 32'h00000002);
        rd_chk("unmapped", 12'h0FC, 32'h0);
        acc(1'b0, DAT, 32'h0);
        rd_chk("load err", STA, 32'h00000006);
        acc(1'b1, STA, 32'h0);
        rd_chk("err clear", STA, 32'h00000002);
        acc(1'b1, DAT, 32'h0000A5C3);
        acc(1'b1, DAT, 32'h00001111);
        rd_chk("store err", STA, 32'h00000008);
        acc(1'b1, STA, 32'h00000020);
        repeat (3) @(posedge pclk);
        rd_chk("out reset", STA, 32'h00000002);
        acc(1'b1, DAT, 32'h0000A5C3);
        rd_chk("store clr", STA, 32'h0);
        far.recv(16, 1'b0, 1'b0, 1'b0, w1);
        check("out msb16", {16'h0, w1}, 32'h0000A5C3);
        rd_chk("store set", STA, 32'h00000002);
        acc(1'b1, STA, 32'h0000A000);
        acc(1'b1, DAT, 32'h000000B4);
        far.recv(8, 1'b1, 1'b0, 1'b0, w1);
        check("out lsb8", {16'h0, w1}, 32'h000000B4);
        acc(1'b1, STA, 32'h00000800);
        fork
            begin
                acc(1'b1, DAT, 32'h00001234);
                acc(1'b1, DAT, 32'h0000C0DE);
            end
            begin
                far.recv(16, 1'b0, 1'b1, 1'b0, w1);
                far.recv(16, 1'b0, 1'b0, 1'b1, w2);
            end
        join
        check("word one", {16'h0, w1}, 32'h00001234);
        check("word two", {16'h0, w2}, 32'h0000C0DE);
        rd_chk("no st err", STA, 32'h00000802);
        acc(1'b1, STA, 32'h00000200);
        far.send(16'h3C5A, 16, 1'b0);
        wait_in(1);
        rd_chk("load set", STA, 32'h00000203);
        rd_chk("in msb16", DAT, 32'h00003C5A);
        rd_chk("load clr", STA, 32'h00000202);
        acc(1'b1, STA, 32'h00005200);
        far.send(16'h0096, 8, 1'b1);
        wait_in(2);
        rd_chk("in lsb8", DAT, 32'h00000096);
        acc(1'b0, DAT, 32'h0);
        acc(1'b1, STA, 32'h00000010);
        repeat (3) @(posedge pclk);
        rd_chk("in reset", STA, 32'h00000002);
        // Single input mode: one word, then acknowledge stays low
        acc(1'b1, STA, 32'h00000100);
        far.send(16'h6E21, 16, 1'b0);
        wait_in(3);
        check("ack off", {31'h0, pins.in_ack_pin}, 32'h0);
        rd_chk("single st", STA, 32'h00000003);
        rd_chk("single dat", DAT, 32'h00006E21);
        check("out pulses", n_out_done, 32'h00000004);
        conclude();
    end
endmodule : handshaked_serial_port_core_bench
